/* core/adc_seq_pkg.sv */
`default_nettype none

package adc_seq_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_PINCFG  = 8'h04;
    localparam logic [7:0] OFS_RESULT  = 8'h08;
    localparam logic [7:0] OFS_FLAG    = 8'h0C;
    localparam logic [7:0] OFS_PORT    = 8'h10;
    localparam logic [7:0] OFS_DIR     = 8'h14;
    localparam logic [7:0] OFS_LATCH   = 8'h18;

    // Field positions inside the flag register
    localparam int FLAG_DONE_BIT  = 0;
    localparam int FLAG_IRQEN_BIT = 1;
    localparam int FLAG_SLOW_BIT  = 2;

    ////////////////////////////////////////////////////////////////////////////
    // Conversion clock select codes
    typedef enum logic [1:0] {
        CLK_OSC_DIV2  = 2'h0,
        CLK_OSC_DIV8  = 2'h1,
        CLK_OSC_DIV32 = 2'h2,
        CLK_RC        = 2'h3
    } clk_sel_e;

    // Control register layout
    typedef struct packed {
        clk_sel_e   clk_sel;
        logic [2:0] channel_select;
        logic       go;
        logic       rsvd;
        logic       converter_on;
    } ctrl_s;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] RST_CTRL   = 8'h00;
    localparam logic [7:0] RST_PINCFG = 8'hFF;
    localparam logic [7:0] RST_DIR    = 8'hFF;
    localparam logic [7:0] RST_LATCH  = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Timing: dividers in system clock cycles per tick, one half bit period per tick; phase counts in ticks
    localparam logic [4:0] HALF_DIV2        = 5'h01;
    localparam logic [4:0] HALF_DIV8        = 5'h04;
    localparam logic [4:0] HALF_DIV32       = 5'h10;
    localparam logic [2:0] INSTR_OSC_CYCLES = 3'h4;
    localparam logic [4:0] HC_FIRST_TRIAL   = 5'h02;
    localparam logic [4:0] HC_FIRST_DECIDE  = 5'h04;
    localparam logic [4:0] HC_CONV_LAST     = 5'h12;
    localparam logic [4:0] HC_SETTLE_LAST   = 5'h03;
    localparam int         SYS_CLK_MHZ      = 200;
    localparam int         MIN_TAD_NS       = 1600;
    localparam int         MIN_TAD_CYCLES   = (MIN_TAD_NS * SYS_CLK_MHZ + 999) / 1000;

    // Compare unit mode that fires the special event trigger
    localparam logic [3:0] COMPARE_MODE_ADC = 4'hB;

endpackage

`default_nettype wire

/* core/half_tick_gen.sv */
`default_nettype none

module half_tick_gen
(
    // Clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       rst_n_i,
    // Control
    input  wire logic       run_i,
    input  wire logic [1:0] clk_sel_i,
    input  wire logic       rc_edge_i,
    // Half bit period pulse
    output logic            half_tick_o
);

    logic [4:0] cnt_ff;
    logic       tick_ff;
    wire  [4:0] half_div;
    wire        wrap;

    // Divisor follows the live select, so a switch takes effect mid-conversion
    assign half_div = (clk_sel_i == adc_seq_pkg::CLK_OSC_DIV2) ? adc_seq_pkg::HALF_DIV2 :
                      (clk_sel_i == adc_seq_pkg::CLK_OSC_DIV8) ? adc_seq_pkg::HALF_DIV8 :
                      adc_seq_pkg::HALF_DIV32;
    assign wrap     = (cnt_ff >= (half_div - 5'h01));

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_ff  <= 5'h00;
            tick_ff <= 1'b0;
        end
        else if (!run_i)
        begin
            cnt_ff  <= 5'h00;
            tick_ff <= 1'b0;
        end
        else if (clk_sel_i == adc_seq_pkg::CLK_RC)
        begin
            cnt_ff  <= 5'h00;
            tick_ff <= rc_edge_i;
        end
        else
        begin
            cnt_ff  <= wrap ? 5'h00 : cnt_ff + 5'h01;
            tick_ff <= wrap;
        end
    end

    assign half_tick_o = tick_ff;

endmodule

`default_nettype wire

/* core/adc_conversion_sequencer.sv */
// Added by the designer: register access over APB and the address map.
`default_nettype none

// Notes on behaviour
// - Port read shows analog pins as zero
// - Output-driven analog pin is still converted
// - Channel and direction never gate sequencing
// - Abort by clearing go keeps old result
// - After abort wait two bit periods, reacquire
// - Clock switch mid-conversion applies to remaining bits
// - RC clock waits one instruction cycle first
// - Sleep completion loads result, may wake device
// - Sleep on oscillator clock aborts, powers off
// - Reset loads register defaults (pin config and direction all ones), module off, aborts
// - Reset leaves result register unmodified
// - Compare trigger sets go, clears timer
// - Trigger ignored when off, timer still cleared
// - Clock select codes div2, div8, div32, RC
// - Completion loads result, clears go, sets flag
// - Full conversion lasts nine and half periods
module adc_conversion_sequencer
(
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Analog front end
    input  wire logic        comp_i,
    output logic      [2:0]  channel_o,
    output logic      [7:0]  dac_code_o,
    output logic             sample_o,
    output logic             power_on_o,
    // Port pins
    input  wire logic [7:0]  pin_i,
    output logic      [7:0]  pin_out_o,
    output logic      [7:0]  pin_oe_o,
    // Core, RC oscillator and compare unit
    input  wire logic        rc_clk_i,
    input  wire logic        sleep_i,
    input  wire logic [3:0]  compare_mode_i,
    input  wire logic        special_event_i,
    output logic             timer_clear_o,
    output logic             wake_o,
    output logic             done_flag_o
);

    typedef enum logic [1:0] {
        ST_ACQ,
        ST_RC_WAIT,
        ST_CONV,
        ST_SETTLE
    } seq_state_e;

    ////////////////////////////////////////////////////////////////////////////
    // State

    seq_state_e          state_ff;
    seq_state_e          nxt_state;
    adc_seq_pkg::ctrl_s  ctrl_ff;
    logic                go_ff;
    logic [7:0]          pincfg_ff;
    logic [7:0]          dir_ff;
    logic [7:0]          latch_ff;
    logic [7:0]          result_ff;
    logic                done_ff;
    logic                irq_en_ff;
    logic [4:0]          hc_ff;
    logic [2:0]          wait_ff;
    logic [7:0]          dac_ff;
    logic [7:0]          mask_ff;
    logic [31:0]         prdata_ff;
    logic                pready_ff;
    logic                pslverr_ff;
    logic                sample_ff;
    logic                power_ff;
    logic                timer_clr_ff;
    logic                wake_ff;
    logic [7:0]          pin_oe_ff;
    logic [7:0]          pin_s1_ff;
    logic [7:0]          pin_s2_ff;
    logic                rc_s1_ff;
    logic                rc_s2_ff;
    logic                rc_s3_ff;
    logic                half_tick;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode

    wire                     setup     = psel_i & ~penable_i;
    wire                     access    = psel_i & penable_i & pready_ff;
    wire                     wr        = access & pwrite_i;
    wire                     sel_ctrl  = (paddr_i == adc_seq_pkg::OFS_CTRL);
    wire                     sel_pcfg  = (paddr_i == adc_seq_pkg::OFS_PINCFG);
    wire                     sel_res   = (paddr_i == adc_seq_pkg::OFS_RESULT);
    wire                     sel_flag  = (paddr_i == adc_seq_pkg::OFS_FLAG);
    wire                     sel_port  = (paddr_i == adc_seq_pkg::OFS_PORT);
    wire                     sel_dir   = (paddr_i == adc_seq_pkg::OFS_DIR);
    wire                     sel_latch = (paddr_i == adc_seq_pkg::OFS_LATCH);
    wire                     mapped    = sel_ctrl | sel_pcfg | sel_res | sel_flag |
                                         sel_port | sel_dir | sel_latch;
    wire                     wr_ctrl   = wr & sel_ctrl;
    wire                     wr_flag   = wr & sel_flag;
    wire adc_seq_pkg::ctrl_s w_ctrl    = adc_seq_pkg::ctrl_s'(pwdata_i[7:0]);

    ////////////////////////////////////////////////////////////////////////////
    // Sequencing decisions; channel and direction are not looked at

    wire       busy        = (state_ff == ST_RC_WAIT) | (state_ff == ST_CONV);
    wire       is_rc       = (ctrl_ff.clk_sel == adc_seq_pkg::CLK_RC);
    wire       turn_off    = wr_ctrl & ~w_ctrl.converter_on;
    wire       trig_hit    = special_event_i & (compare_mode_i == adc_seq_pkg::COMPARE_MODE_ADC);
    // Go only counts when the module was already on, not in the enabling write
    wire       sw_start    = wr_ctrl & w_ctrl.go & w_ctrl.converter_on &
                             ctrl_ff.converter_on & (state_ff == ST_ACQ);
    wire       trig_start  = trig_hit & ctrl_ff.converter_on &
                             (state_ff == ST_ACQ) & ~turn_off;
    wire       start       = sw_start | trig_start;
    wire       sw_abort    = wr_ctrl & busy & ~w_ctrl.go;
    wire       sleep_abort = sleep_i & busy & ~is_rc;
    wire       abort       = sw_abort | sleep_abort | (busy & turn_off);
    wire       conv_end    = (state_ff == ST_CONV) & half_tick &
                             (hc_ff == adc_seq_pkg::HC_CONV_LAST);
    wire       decide      = (state_ff == ST_CONV) & half_tick & ~hc_ff[0] &
                             (hc_ff >= adc_seq_pkg::HC_FIRST_DECIDE);
    wire [7:0] decided     = comp_i ? dac_ff : (dac_ff & ~mask_ff);
    wire       run_ticks   = (state_ff == ST_CONV) | (state_ff == ST_SETTLE);
    wire       rc_edge     = rc_s2_ff ^ rc_s3_ff;
    wire [5:0] full_div    = {ctrl_ff.clk_sel == adc_seq_pkg::CLK_OSC_DIV32,
                              ctrl_ff.clk_sel == adc_seq_pkg::CLK_OSC_DIV8,
                              3'h0,
                              ctrl_ff.clk_sel == adc_seq_pkg::CLK_OSC_DIV2};
    // Flags a bit period below the minimum; results would be invalid
    wire       tad_short   = ~is_rc & ((32'(full_div) * 32'd2) < 32'(adc_seq_pkg::MIN_TAD_CYCLES));

    ////////////////////////////////////////////////////////////////////////////
    // Read mux

    wire [31:0] rd_data =
        sel_ctrl  ? {24'h000000, ctrl_ff.clk_sel, ctrl_ff.channel_select, go_ff,
                     1'b0, ctrl_ff.converter_on} :
        sel_pcfg  ? {24'h000000, pincfg_ff} :
        sel_res   ? {24'h000000, result_ff} :
        sel_flag  ? {29'h00000000, tad_short, irq_en_ff, done_ff} :
        sel_port  ? {24'h000000, pin_s2_ff & ~pincfg_ff} :
        sel_dir   ? {24'h000000, dir_ff} :
        sel_latch ? {24'h000000, latch_ff} :
        32'h00000000;

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer

    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_ACQ:
                if (start)
                    nxt_state = is_rc ? ST_RC_WAIT : ST_CONV;
            ST_RC_WAIT:
                if (abort)
                    nxt_state = ST_SETTLE;
                else if (wait_ff == (adc_seq_pkg::INSTR_OSC_CYCLES - 3'h1))
                    nxt_state = ST_CONV;
            ST_CONV:
                if (abort || conv_end)
                    nxt_state = ST_SETTLE;
            ST_SETTLE:
                if (half_tick && hc_ff == adc_seq_pkg::HC_SETTLE_LAST)
                    nxt_state = ST_ACQ;
        endcase
    end

    half_tick_gen u_ticks
    (
        .sys_clk_i   (sys_clk_i),
        .rst_n_i     (rst_n_i),
        .run_i       (run_ticks & ~abort),
        .clk_sel_i   (ctrl_ff.clk_sel),
        .rc_edge_i   (rc_edge),
        .half_tick_o (half_tick)
    );

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_ff <= ST_ACQ;
            hc_ff    <= 5'h00;
            wait_ff  <= 3'h0;
            go_ff    <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            hc_ff    <= (nxt_state != state_ff) ? 5'h00 : hc_ff + {4'h0, half_tick};
            wait_ff  <= (state_ff == ST_RC_WAIT) ? wait_ff + 3'h1 : 3'h0;
            go_ff    <= start | (go_ff & ~abort & ~conv_end);
        end
    end

    // Successive approximation trial register
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            dac_ff  <= 8'h00;
            mask_ff <= 8'h00;
        end
        else if (start)
        begin
            dac_ff  <= 8'h00;
            mask_ff <= 8'h00;
        end
        else if ((state_ff == ST_CONV) && half_tick && hc_ff == adc_seq_pkg::HC_FIRST_TRIAL)
        begin
            dac_ff  <= 8'h80;
            mask_ff <= 8'h80;
        end
        else if (decide)
        begin
            dac_ff  <= decided | (mask_ff >> 1);
            mask_ff <= mask_ff >> 1;
        end
    end

    // No reset at all: content after power-up is undefined
    always_ff @(posedge sys_clk_i)
    begin
        if (conv_end)
            result_ff <= decided;
        else if (wr && sel_res)
            result_ff <= pwdata_i[7:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers and bus answer

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ctrl_ff   <= adc_seq_pkg::ctrl_s'(adc_seq_pkg::RST_CTRL);
            pincfg_ff <= adc_seq_pkg::RST_PINCFG;
            dir_ff    <= adc_seq_pkg::RST_DIR;
            latch_ff  <= adc_seq_pkg::RST_LATCH;
            done_ff   <= 1'b0;
            irq_en_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
            begin
                ctrl_ff.clk_sel        <= w_ctrl.clk_sel;
                ctrl_ff.channel_select <= w_ctrl.channel_select;
                ctrl_ff.converter_on   <= w_ctrl.converter_on;
            end
            if (wr && sel_pcfg)
                pincfg_ff <= pwdata_i[7:0];
            if (wr && sel_dir)
                dir_ff <= pwdata_i[7:0];
            if (wr && sel_latch)
                latch_ff <= pwdata_i[7:0];
            if (wr_flag)
                irq_en_ff <= pwdata_i[adc_seq_pkg::FLAG_IRQEN_BIT];
            // Set beats a simultaneous write-one clear
            done_ff    <= conv_end |
                          (done_ff & ~(wr_flag & pwdata_i[adc_seq_pkg::FLAG_DONE_BIT]));
            pready_ff  <= setup;
            pslverr_ff <= setup & ~mapped;
            if (setup)
                prdata_ff <= rd_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pins, front end and events

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pin_s1_ff    <= 8'h00;
            pin_s2_ff    <= 8'h00;
            rc_s1_ff     <= 1'b0;
            rc_s2_ff     <= 1'b0;
            rc_s3_ff     <= 1'b0;
            pin_oe_ff    <= 8'h00;
            sample_ff    <= 1'b0;
            power_ff     <= 1'b0;
            timer_clr_ff <= 1'b0;
            wake_ff      <= 1'b0;
        end
        else
        begin
            pin_s1_ff    <= pin_i;
            pin_s2_ff    <= pin_s1_ff;
            rc_s1_ff     <= rc_clk_i;
            rc_s2_ff     <= rc_s1_ff;
            rc_s3_ff     <= rc_s2_ff;
            // Driven pins stay selectable; the front end converts the driven level
            pin_oe_ff    <= ~dir_ff;
            sample_ff    <= (nxt_state == ST_ACQ) & ctrl_ff.converter_on;
            power_ff     <= ctrl_ff.converter_on & ~(sleep_i & ~is_rc);
            timer_clr_ff <= trig_hit;
            wake_ff      <= conv_end & sleep_i & irq_en_ff;
        end
    end

    assign prdata_o      = prdata_ff;
    assign pready_o      = pready_ff;
    assign pslverr_o     = pslverr_ff;
    assign channel_o     = ctrl_ff.channel_select;
    assign dac_code_o    = dac_ff;
    assign sample_o      = sample_ff;
    assign power_on_o    = power_ff;
    assign pin_out_o     = latch_ff;
    assign pin_oe_o      = pin_oe_ff;
    assign timer_clear_o = timer_clr_ff;
    assign wake_o        = wake_ff;
    assign done_flag_o   = done_ff;

endmodule

`default_nettype wire

/* verif/adc_seq_checker_assertions.sv */
`default_nettype none
////////////////////////////////////////
module adc_seq_checker
(
    // Clock and reset
    input wire logic       sys_clk_i,
    input wire logic       rst_n_i,
    // Watched ports
    input wire logic       sample_o,
    input wire logic       power_on_o,
    input wire logic [7:0] pin_oe_o,
    input wire logic       sleep_i,
    input wire logic [3:0] compare_mode_i,
    input wire logic       special_event_i,
    input wire logic       timer_clear_o,
    input wire logic       wake_o,
    input wire logic       done_flag_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    logic trig;
    // Timer clear ignores converter_on
    assign trig = special_event_i && compare_mode_i == adc_seq_pkg::COMPARE_MODE_ADC;
    ////////////////////////////////////////
    reset_out_a: assert property ($rose(rst_n_i) |-> !power_on_o && !done_flag_o &&
        pin_oe_o == 8'h00) else $error("outputs not cleared by reset");
    timer_set_a: assert property (trig |=> timer_clear_o)
        else $error("timer clear missing");
    timer_cause_a: assert property (timer_clear_o |-> $past(trig))
        else $error("timer clear without event");
    wake_cause_a: assert property (wake_o |-> done_flag_o && $past(sleep_i))
        else $error("wake without sleep completion");
    wake_pulse_a: assert property (wake_o |=> !wake_o)
        else $error("wake longer than one cycle");
    settle_gap_a: assert property ($rose(done_flag_o) |-> !sample_o [*3])
        else $error("acquisition before settle");
    power_gate_a: assert property (sample_o |-> power_on_o)
        else $error("acquiring while unpowered");
    done_conv_a: assert property ($rose(done_flag_o) |-> !$past(sample_o))
        else $error("done flag without conversion");
endmodule
////////////////////////////////////////
bind adc_conversion_sequencer adc_seq_checker u_chk (.sys_clk_i, .rst_n_i, .sample_o,
    .power_on_o, .pin_oe_o, .sleep_i, .compare_mode_i, .special_event_i, .timer_clear_o,
    .wake_o, .done_flag_o);
`default_nettype wire

/* verif/adc_front_model.sv */
`default_nettype none
////////////////////////////////////////
module adc_front_model
#(
    parameter int RC_HALF_NS = 53
)
(
    // Converter side
    input  wire logic [2:0]  channel_i,
    input  wire logic [7:0]  dac_code_i,
    input  wire logic [7:0]  pin_out_i,
    input  wire logic [7:0]  pin_oe_i,
    // Analog levels, one byte a channel
    input  wire logic [63:0] level_i,
    // Comparator and RC oscillator
    output logic             comp_o,
    output var logic         rc_clk_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] level;
    // Driven pin converts its own digital level
    assign level = pin_oe_i[channel_i] ? {8{pin_out_i[channel_i]}} : level_i[channel_i*8 +: 8];
    assign comp_o = level >= dac_code_i;
    // Free running, any phase
    initial
    begin
        rc_clk_o = 1'b0;
        forever #(RC_HALF_NS) rc_clk_o = ~rc_clk_o;
    end
endmodule
`default_nettype wire

/* verif/adc_conversion_sequencer_bench.sv */
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin err_total++; \
    $display("wrong value %s exp %0h got %0h", n, e, g); end end
module adc_conversion_sequencer_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [63:0] LEVELS = 64'hF0C396693C0F815A;
    localparam logic [7:0]  RA [5] = '{adc_seq_pkg::OFS_CTRL, adc_seq_pkg::OFS_PINCFG,
        adc_seq_pkg::OFS_DIR, adc_seq_pkg::OFS_LATCH, adc_seq_pkg::OFS_FLAG};
    localparam logic [7:0]  RV [5] = '{adc_seq_pkg::RST_CTRL, adc_seq_pkg::RST_PINCFG,
        adc_seq_pkg::RST_DIR, adc_seq_pkg::RST_LATCH, 8'h04};
    localparam logic [4:0]  HV [4] = '{adc_seq_pkg::HALF_DIV2, adc_seq_pkg::HALF_DIV8,
        adc_seq_pkg::HALF_DIV32, 5'h00};
    logic        clk, rst_n, psel, pen, pwrite, sleep, ev, e;
    logic        pready, perr, comp, smp, pwr_on, rc, tclr, wake, done;
    logic [2:0]  chan;
    logic [3:0]  mode;
    logic [7:0]  paddr, pin, dac, pout, poe, pin_w;
    logic [31:0] pwdata, prdata, q;
    int          err_total, check_count, cyc, wake_cnt;
    // Wire level from both drivers of each pin
    assign pin_w = (poe & pout) | (~poe & pin);
    adc_conversion_sequencer uut
    (
        .sys_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(pen), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(perr), .comp_i(comp), .channel_o(chan), .dac_code_o(dac), .sample_o(smp),
        .power_on_o(pwr_on), .pin_i(pin_w), .pin_out_o(pout), .pin_oe_o(poe), .rc_clk_i(rc),
        .sleep_i(sleep), .compare_mode_i(mode), .special_event_i(ev), .timer_clear_o(tclr),
        .wake_o(wake), .done_flag_o(done)
    );
    adc_front_model far (.channel_i(chan), .dac_code_i(dac), .pin_out_i(pout), .pin_oe_i(poe),
        .level_i(LEVELS), .comp_o(comp), .rc_clk_o(rc));
    ////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (wake === 1'b1) wake_cnt++;
        if (cyc == 20000)
        begin
            err_total++;
            summarize();
        end
    end
    ////////////////////////////////////////
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        e = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    function automatic logic [31:0] ctl(input logic [1:0] s, input logic [2:0] c,
                                        input logic g, input logic on);
        return {24'h0, s, c, g, 1'b0, on};
    endfunction
    function automatic logic [7:0] lv(input int k);
        return LEVELS[k*8 +: 8];
    endfunction
    task automatic wait_smp(output int n);
        for (n = 0; smp !== 1'b1; n++) @(posedge clk);
    endtask
    task automatic wd(output int n);
        for (n = 0; done !== 1'b1; n++) @(posedge clk);
    endtask
    // Enable first, go in a later write
    task automatic go(input logic [1:0] s, input logic [2:0] c, input logic irq);
        int n;
        apb(1'b1, adc_seq_pkg::OFS_FLAG, {30'h0, irq, 1'b1});
        apb(1'b1, adc_seq_pkg::OFS_CTRL, ctl(s, c, 1'b0, 1'b1));
        wait_smp(n);
        apb(1'b1, adc_seq_pkg::OFS_CTRL, ctl(s, c, 1'b1, 1'b1));
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] x);
        apb(1'b0, a, 32'h0);
        `CHK("read", x, q[7:0]);
    endtask
    ////////////////////////////////////////
    task automatic t_reset;
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b0, RA[i], 32'h0);
            `CHK("reset value", RV[i], q[7:0]);
        end
        apb(1'b0, 8'h1C, 32'h0);
        `CHK("unmapped", 33'h100000000, {e, q});
        apb(1'b1, adc_seq_pkg::OFS_CTRL, ctl(2'h0, 3'h0, 1'b1, 1'b1));
        apb(1'b0, adc_seq_pkg::OFS_CTRL, 32'h0);
        `CHK("go in enabling write", 1'b0, q[2]);
        $display("test reset done");
    endtask
    task automatic t_pins;
        int n;
        apb(1'b1, adc_seq_pkg::OFS_PINCFG, 32'h0F);
        apb(1'b0, adc_seq_pkg::OFS_PORT, 32'h0);
        `CHK("port", 8'hA0, q[7:0]);
        apb(1'b1, adc_seq_pkg::OFS_LATCH, 32'h04);
        apb(1'b1, adc_seq_pkg::OFS_DIR, 32'hFB);
        for (int b = 1; b >= 0; b--)
        begin
            apb(1'b1, adc_seq_pkg::OFS_LATCH, {29'h0, b[0], 2'h0});
            go(2'h0, 3'h2, 1'b0);
            wd(n);
            `CHK("pin oe", 8'h04, poe);
            rd_chk(adc_seq_pkg::OFS_RESULT, {8{b[0]}});
        end
        apb(1'b1, adc_seq_pkg::OFS_DIR, 32'hFF);
        $display("test pins done");
    endtask
    task automatic t_conv;
        int n;
        for (int s = 0; s < 4; s++)
        begin
            go(2'(s), 3'(s * 2 + 1), 1'b0);
            wd(n);
            if (s < 3)
                `CHK("conv time", 1'b1, n >= 19 * HV[s] && n <= 20 * HV[s] + 2);
            rd_chk(adc_seq_pkg::OFS_RESULT, lv(s * 2 + 1));
            apb(1'b0, adc_seq_pkg::OFS_FLAG, 32'h0);
            `CHK("short", s < 3 && 2 * HV[s] < adc_seq_pkg::MIN_TAD_CYCLES, q[2]);
            `CHK("flag", 1'b1, q[0]);
            rd_chk(adc_seq_pkg::OFS_CTRL, ctl(2'(s), 3'(s * 2 + 1), 1'b0, 1'b1));
        end
        $display("test conversions done");
    endtask
    task automatic t_abort;
        int n;
        go(2'h2, 3'h3, 1'b0);
        repeat (190) @(posedge clk);
        apb(1'b1, adc_seq_pkg::OFS_CTRL, ctl(2'h0, 3'h3, 1'b1, 1'b1));
        wd(n);
        `CHK("switch", 1'b1, n < 16);
        apb(1'b1, adc_seq_pkg::OFS_RESULT, 32'h5A);
        go(2'h2, 3'h3, 1'b0);
        repeat (40) @(posedge clk);
        apb(1'b1, adc_seq_pkg::OFS_CTRL, ctl(2'h2, 3'h3, 1'b0, 1'b1));
        wait_smp(n);
        `CHK("settle", 1'b1, n >= 4 * 16 && n <= 5 * 16 + 2);
        `CHK("channel", 3'h3, chan);
        rd_chk(adc_seq_pkg::OFS_RESULT, 8'h5A);
        rd_chk(adc_seq_pkg::OFS_FLAG, 8'h04);
        $display("test abort done");
    endtask
    task automatic t_sleep;
        int n;
        int w;
        go(2'h2, 3'h5, 1'b0);
        repeat (20) @(posedge clk);
        sleep <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK("power", 1'b0, pwr_on);
        rd_chk(adc_seq_pkg::OFS_CTRL, ctl(2'h2, 3'h5, 1'b0, 1'b1));
        sleep <= 1'b0;
        rd_chk(adc_seq_pkg::OFS_RESULT, 8'h5A);
        for (int i = 1; i >= 0; i--)
        begin
            w = wake_cnt;
            go(2'h3, 3'(7 - i), i[0]);
            sleep <= 1'b1;
            wd(n);
            repeat (3) @(posedge clk);
            `CHK("wake", w + i, wake_cnt);
            sleep <= 1'b0;
            rd_chk(adc_seq_pkg::OFS_RESULT, lv(7 - i));
            rd_chk(adc_seq_pkg::OFS_CTRL, ctl(2'h3, 3'(7 - i), 1'b0, 1'b1));
        end
        $display("test sleep done");
    endtask
    task automatic pulse(input logic t, input logic g);
        @(posedge clk);
        ev <= 1'b1;
        @(posedge clk);
        ev <= 1'b0;
        @(posedge clk);
        `CHK("timer clear", t, tclr);
        apb(1'b0, adc_seq_pkg::OFS_CTRL, 32'h0);
        `CHK("trigger go", g, q[2]);
    endtask
    task automatic t_trig;
        int n;
        apb(1'b1, adc_seq_pkg::OFS_FLAG, 32'h1);
        apb(1'b1, adc_seq_pkg::OFS_CTRL, ctl(2'h0, 3'h4, 1'b0, 1'b1));
        wait_smp(n);
        mode <= adc_seq_pkg::COMPARE_MODE_ADC;
        pulse(1'b1, 1'b1);
        wd(n);
        rd_chk(adc_seq_pkg::OFS_RESULT, lv(4));
        apb(1'b1, adc_seq_pkg::OFS_CTRL, ctl(2'h0, 3'h4, 1'b0, 1'b0));
        pulse(1'b1, 1'b0);
        apb(1'b1, adc_seq_pkg::OFS_CTRL, ctl(2'h0, 3'h4, 1'b0, 1'b1));
        mode <= 4'hA;
        pulse(1'b0, 1'b0);
        $display("test trigger done");
    endtask
    task automatic t_rst;
        go(2'h1, 3'h1, 1'b0);
        repeat (10) @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(adc_seq_pkg::OFS_CTRL, 8'h00);
        `CHK("power", 1'b0, pwr_on);
        rd_chk(adc_seq_pkg::OFS_RESULT, lv(4));
        $display("test reset in flight done");
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////
    initial
    begin
        {rst_n, psel, pen, pwrite, sleep, ev} = 6'h00;
        {paddr, pwdata, mode} = 44'h0;
        pin = 8'hA5;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_pins();
        t_conv();
        t_abort();
        t_sleep();
        t_trig();
        t_rst();
        summarize();
    end
endmodule
`default_nettype wire
